/* File: power_reset_status_pkg.sv */
// Package with register map, field layout and bus carrier types.
package power_reset_status_pkg;

	localparam logic [11:0] OFS_RESET_CAUSE     = 12'h400;
	localparam logic [11:0] OFS_RAM_STATUS      = 12'h428;
	localparam logic [11:0] OFS_SLEEP_TRIGGER   = 12'h500;
	localparam logic [11:0] OFS_FAIL_CONFIG     = 12'h510;
	localparam logic [11:0] OFS_SCRATCH_A       = 12'h51C;
	localparam logic [11:0] OFS_SCRATCH_B       = 12'h520;
	localparam logic [11:0] OFS_LEGACY_RAM      = 12'h524;
	localparam logic [11:0] OFS_IRQ_STATUS      = 12'h600;
	localparam logic [11:0] OFS_IRQ_MASK        = 12'h604;

	// Reset-cause bit positions
	localparam int BIT_CPU_STALL    = 3;
	localparam int BIT_PIN_WAKE     = 16;
	localparam int BIT_COMP_WAKE    = 17;
	localparam int BIT_DEBUG_WAKE   = 18;
	localparam int BIT_FIELD_WAKE   = 19;

	localparam int BIT_FAIL_ENABLE  = 0;
	localparam int FAIL_THR_LSB     = 1;
	localparam int FAIL_THR_MSB     = 4;
	localparam int BIT_SLEEP_GO     = 0;

	localparam logic [31:0] RST_FAIL_CONFIG = 32'h0000_0000;
	localparam logic [7:0]  RST_SCRATCH     = 8'h00;
	localparam logic [1:0]  RST_LEGACY_RAM  = 2'h3;
	localparam logic [4:0]  RST_CAUSE       = 5'h00;
	localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

	// Interrupt status bits: one per cause flag, order as cause_t
	localparam int IRQ_BITS = 5;

	typedef struct packed {
		logic field_wake;
		logic debug_wake;
		logic comp_wake;
		logic pin_wake;
		logic cpu_stall;
	} cause_t;

	typedef struct packed {
		logic [11:0] address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} bus_req_t;

	typedef struct packed {
		logic [3:0] threshold;
		logic       enable;
	} fail_cfg_t;

endpackage

/* File: power_reset_status_regs.sv */
// Power-management status and control register bank on Avalon-MM.
//
// Notes on behaviour
// - Cause register flag shows a processor lock-up reset, else zero.
// - Cause flag set when deep-sleep wake came from pin-sense signal.
// - Cause flag set when wake came from comparator analog-detect.
// - Cause flag set when wake came from entering debug interface mode.
// - Cause flag set when wake came from near-field detection.
// - RAM status bits 0..3 read one while any section of block powered.
// - Status blocks group section S0 of RAM pairs 0/1,2/3,4/5,6/7.
// - Writing one to deep-sleep trigger bit 0 enters deep sleep.
// - Comparator config bit 0 enables comparator; register resets to zero.
// - Config bits 4..1 select threshold, codes 4..15 give 1.7..2.8 V.
// - Two eight-bit scratch registers read and write freely, reset zero.
// - Scratch registers are retained across low-power states.
// - Legacy RAM power bits 0,1 keep blocks on; resets to three.
// - Legacy block 0 is RAM 0 sections S0,S1; block 1 RAM 1.
// - Legacy RAM power register is retained through low-power states.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps

module power_reset_status_regs
	import power_reset_status_pkg::*;
(
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST,
	// Retention-domain reset, only at power-on
	input  wire logic        POR,
	// Avalon-MM slave
	input  wire logic [11:0] ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [31:0] WRITEDATA,
	input  wire logic [3:0]  BYTEENABLE,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	output logic      [1:0]  RESPONSE,
	// Reset and wake event pulses
	input  wire logic        CPU_STALL_EVENT,
	input  wire logic        PIN_WAKE_EVENT,
	input  wire logic        ANALOG_DETECT_SIGNAL,
	input  wire logic        DEBUG_ENTRY_EVENT,
	input  wire logic        FIELD_DETECT_EVENT,
	// RAM section power state, one bit per RAM for section S0
	input  wire logic [7:0]  RAM_SECTION0_ON,
	// Power control outputs
	output logic             DEEP_SLEEP_REQUEST,
	output logic             FAIL_COMPARATOR_ENABLE,
	output logic      [3:0]  FAIL_THRESHOLD,
	output logic      [3:0]  LEGACY_RAM_SECTION_KEEP,
	// Interrupt
	output logic             IRQ
);

	bus_req_t          req;
	logic              ack_reg;
	logic              wr_stb;
	logic              rd_stb;
	cause_t            cause_reg;
	cause_t            cause_next;
	cause_t            events;
	fail_cfg_t         fail_cfg_reg;
	logic [7:0]        scratch_a_reg;
	logic [7:0]        scratch_b_reg;
	logic [1:0]        legacy_ram_reg;
	logic [3:0]        ram_status;
	logic [IRQ_BITS-1:0] irq_status_reg;
	logic [IRQ_BITS-1:0] irq_mask_reg;
	logic              sleep_reg;
	logic [31:0]       rdata_next;
	logic [31:0]       rdata_reg;
	logic              hit;

	assign req = '{address: ADDRESS, read: READ, write: WRITE,
		writedata: WRITEDATA, byteenable: BYTEENABLE};

	// Byte-lane mask: lanes left out of a read return zero
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic is_write(input bus_req_t r,
		input logic [11:0] ofs);
		is_write = r.write && (r.address == ofs);
	endfunction

	// One wait state: request taken at the edge where ack is high
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (READ || WRITE) && !ack_reg;
		end
	end

	assign WAITREQUEST = (READ || WRITE) && !ack_reg;
	assign wr_stb = WRITE && ack_reg;
	assign rd_stb = READ && ack_reg;

	// Per-register write enables, true only at the accepting edge
	logic              we_cause_low;
	logic              we_cause_wake;
	logic              we_sleep;
	logic              we_cfg;
	logic              we_scratch_a;
	logic              we_scratch_b;
	logic              we_legacy;
	logic              we_irq_status;
	logic              we_irq_mask;

	// Lock-up flag lives in lane 0, the wake flags in lane 2
	assign we_cause_low  = wr_stb && is_write(req, OFS_RESET_CAUSE)
		&& BYTEENABLE[0];
	assign we_cause_wake = wr_stb && is_write(req, OFS_RESET_CAUSE)
		&& BYTEENABLE[2];
	assign we_sleep      = wr_stb && is_write(req, OFS_SLEEP_TRIGGER)
		&& BYTEENABLE[0];
	assign we_cfg        = wr_stb && is_write(req, OFS_FAIL_CONFIG)
		&& BYTEENABLE[0];
	assign we_scratch_a  = wr_stb && is_write(req, OFS_SCRATCH_A)
		&& BYTEENABLE[0];
	assign we_scratch_b  = wr_stb && is_write(req, OFS_SCRATCH_B)
		&& BYTEENABLE[0];
	assign we_legacy     = wr_stb && is_write(req, OFS_LEGACY_RAM)
		&& BYTEENABLE[0];
	assign we_irq_status = wr_stb && is_write(req, OFS_IRQ_STATUS)
		&& BYTEENABLE[0];
	assign we_irq_mask   = wr_stb && is_write(req, OFS_IRQ_MASK)
		&& BYTEENABLE[0];

	assign events = '{field_wake: FIELD_DETECT_EVENT,
		debug_wake: DEBUG_ENTRY_EVENT,
		comp_wake: ANALOG_DETECT_SIGNAL,
		pin_wake: PIN_WAKE_EVENT,
		cpu_stall: CPU_STALL_EVENT};

	// Cause flags: write-one-to-clear, a new event wins over the clear
	always_comb begin
		cause_next = cause_reg;
		if (we_cause_wake) begin
			cause_next.pin_wake   = cause_reg.pin_wake
				& ~WRITEDATA[BIT_PIN_WAKE];
			cause_next.comp_wake  = cause_reg.comp_wake
				& ~WRITEDATA[BIT_COMP_WAKE];
			cause_next.debug_wake = cause_reg.debug_wake
				& ~WRITEDATA[BIT_DEBUG_WAKE];
			cause_next.field_wake = cause_reg.field_wake
				& ~WRITEDATA[BIT_FIELD_WAKE];
		end
		if (we_cause_low) begin
			cause_next.cpu_stall = cause_reg.cpu_stall
				& ~WRITEDATA[BIT_CPU_STALL];
		end
		cause_next = cause_next | events;
	end

	// Cause flags sit in the retention domain: RST leaves them alone
	always_ff @(posedge CLOCK) begin
		if (POR) begin
			cause_reg <= RST_CAUSE;
		end else begin
			cause_reg <= cause_next;
		end
	end

	// Deep-sleep trigger is write-only and produces a one-cycle pulse
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sleep_reg <= 1'b0;
		end else begin
			sleep_reg <= we_sleep && WRITEDATA[BIT_SLEEP_GO];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			fail_cfg_reg <= fail_cfg_t'(RST_FAIL_CONFIG[4:0]);
		end else if (we_cfg) begin
			fail_cfg_reg.enable    <= WRITEDATA[BIT_FAIL_ENABLE];
			fail_cfg_reg.threshold <= WRITEDATA[FAIL_THR_MSB:FAIL_THR_LSB];
		end
	end

	// Codes below 4 are stored as written; the comparator clamps them
	assign FAIL_COMPARATOR_ENABLE = fail_cfg_reg.enable;
	assign FAIL_THRESHOLD = fail_cfg_reg.threshold;

	// Retained registers reset only at power-on, not on RST
	always_ff @(posedge CLOCK) begin
		if (POR) begin
			scratch_a_reg <= RST_SCRATCH;
		end else if (we_scratch_a) begin
			scratch_a_reg <= WRITEDATA[7:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (POR) begin
			scratch_b_reg <= RST_SCRATCH;
		end else if (we_scratch_b) begin
			scratch_b_reg <= WRITEDATA[7:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (POR) begin
			legacy_ram_reg <= RST_LEGACY_RAM;
		end else if (we_legacy) begin
			legacy_ram_reg <= WRITEDATA[1:0];
		end
	end

	// Each legacy block drives both sections S0 and S1 of its RAM
	assign LEGACY_RAM_SECTION_KEEP = {{2{legacy_ram_reg[1]}},
		{2{legacy_ram_reg[0]}}};

	// Each status block ORs section S0 of a pair of RAMs
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_blk
			assign ram_status[g] = RAM_SECTION0_ON[2*g]
				| RAM_SECTION0_ON[2*g+1];
		end
	endgenerate

	// Interrupt status: sticky, write one to clear, set wins
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			irq_status_reg <= '0;
		end else if (we_irq_status) begin
			irq_status_reg <= (irq_status_reg
				& ~WRITEDATA[IRQ_BITS-1:0]) | events;
		end else begin
			irq_status_reg <= irq_status_reg | events;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			irq_mask_reg <= '0;
		end else if (we_irq_mask) begin
			irq_mask_reg <= WRITEDATA[IRQ_BITS-1:0];
		end
	end

	assign IRQ = |(irq_status_reg & irq_mask_reg);

	// Read mux
	always_comb begin
		rdata_next = UNMAPPED_READ;
		hit = 1'b1;
		if (ADDRESS == OFS_RESET_CAUSE) begin
			rdata_next[BIT_CPU_STALL]  = cause_reg.cpu_stall;
			rdata_next[BIT_PIN_WAKE]   = cause_reg.pin_wake;
			rdata_next[BIT_COMP_WAKE]  = cause_reg.comp_wake;
			rdata_next[BIT_DEBUG_WAKE] = cause_reg.debug_wake;
			rdata_next[BIT_FIELD_WAKE] = cause_reg.field_wake;
		end else if (ADDRESS == OFS_RAM_STATUS) begin
			rdata_next[3:0] = ram_status;
		end else if (ADDRESS == OFS_SLEEP_TRIGGER) begin
			rdata_next = UNMAPPED_READ;
		end else if (ADDRESS == OFS_FAIL_CONFIG) begin
			rdata_next[4:0] = fail_cfg_reg;
		end else if (ADDRESS == OFS_SCRATCH_A) begin
			rdata_next[7:0] = scratch_a_reg;
		end else if (ADDRESS == OFS_SCRATCH_B) begin
			rdata_next[7:0] = scratch_b_reg;
		end else if (ADDRESS == OFS_LEGACY_RAM) begin
			rdata_next[1:0] = legacy_ram_reg;
		end else if (ADDRESS == OFS_IRQ_STATUS) begin
			rdata_next[IRQ_BITS-1:0] = irq_status_reg;
		end else if (ADDRESS == OFS_IRQ_MASK) begin
			rdata_next[IRQ_BITS-1:0] = irq_mask_reg;
		end else begin
			hit = 1'b0;
		end
	end

	// Read data registered in the wait cycle so it stands at the ack edge
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rdata_reg <= '0;
		end else if (READ && !ack_reg) begin
			rdata_reg <= rdata_next & lane_mask(BYTEENABLE);
		end
	end

	logic unused_hit;
	assign unused_hit = hit & rd_stb;

	assign READDATA = rdata_reg;
	assign RESPONSE = 2'h0;
	assign DEEP_SLEEP_REQUEST = sleep_reg;

endmodule

/* File: power_reset_status_regs_assertions.sv */
// Checker for the power and reset register bank ports.
`timescale 1ns/1ps

module prs_checker
	import power_reset_status_pkg::*;
(
	// Clock, reset and bus
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic [11:0] ADDRESS,
	input wire logic        READ,
	input wire logic        WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0]  BYTEENABLE,
	input wire logic [31:0] READDATA,
	input wire logic        WAITREQUEST,
	// Power side
	input wire logic [7:0]  RAM_SECTION0_ON,
	input wire logic        DEEP_SLEEP_REQUEST,
	input wire logic        FAIL_COMPARATOR_ENABLE,
	input wire logic [3:0]  FAIL_THRESHOLD,
	input wire logic [3:0]  LEGACY_RAM_SECTION_KEEP,
	input wire logic        IRQ
);
	logic       wr_take;
	logic       slp_take;
	logic       cfg_take;
	logic       leg_take;
	logic [7:0] ram_q;

	assign wr_take = WRITE && !WAITREQUEST && BYTEENABLE[0];
	assign slp_take = wr_take && ADDRESS == OFS_SLEEP_TRIGGER && WRITEDATA[0];
	assign cfg_take = wr_take && ADDRESS == OFS_FAIL_CONFIG;
	assign leg_take = wr_take && ADDRESS == OFS_LEGACY_RAM;

	// Read data is captured one edge before the taking edge
	always_ff @(posedge CLOCK) begin
		ram_q <= RAM_SECTION0_ON;
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	a_wait_once: assert property ((READ || WRITE) && WAITREQUEST |=>
		!WAITREQUEST) else $error("wait state too long");
	a_sleep_pulse: assert property (slp_take |=> DEEP_SLEEP_REQUEST
		##1 !DEEP_SLEEP_REQUEST) else $error("sleep pulse wrong");
	a_sleep_cause: assert property (DEEP_SLEEP_REQUEST |->
		$past(slp_take)) else $error("sleep pulse without write");
	a_cfg_load: assert property (cfg_take |=>
		FAIL_COMPARATOR_ENABLE == $past(WRITEDATA[0]) &&
		FAIL_THRESHOLD == $past(WRITEDATA[4:1])) else $error("config load");
	a_cfg_hold: assert property (!cfg_take |=> $stable(FAIL_THRESHOLD)
		&& $stable(FAIL_COMPARATOR_ENABLE)) else $error("config moved");
	a_legacy_map: assert property (leg_take |=>
		LEGACY_RAM_SECTION_KEEP == {{2{$past(WRITEDATA[1])}},
		{2{$past(WRITEDATA[0])}}}) else $error("legacy keep map");
	a_legacy_hold: assert property (!leg_take |=>
		$stable(LEGACY_RAM_SECTION_KEEP)) else $error("legacy keep moved");
	a_ram_status: assert property (READ && !WAITREQUEST &&
		ADDRESS == OFS_RAM_STATUS |-> READDATA[3:0] == {|ram_q[7:6],
		|ram_q[5:4], |ram_q[3:2], |ram_q[1:0]}) else $error("ram status");

	c_sleep: cover property (slp_take);
	c_irq: cover property ($rose(IRQ));
	c_legacy: cover property (leg_take);
endmodule

bind power_reset_status_regs prs_checker prs_checker_inst (.CLOCK, .RST,
	.ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
	.WAITREQUEST, .RAM_SECTION0_ON, .DEEP_SLEEP_REQUEST,
	.FAIL_COMPARATOR_ENABLE, .FAIL_THRESHOLD, .LEGACY_RAM_SECTION_KEEP, .IRQ);

/* File: power_reset_status_regs_test.sv */
// Self-checking bench for the power and reset register bank.
`timescale 1ns/1ps

module power_reset_status_regs_test import power_reset_status_pkg::*;;
	logic        CLOCK, RST, POR, READ, WRITE, WAITREQUEST, IRQ;
	logic        DEEP_SLEEP_REQUEST, FAIL_COMPARATOR_ENABLE;
	logic [11:0] ADDRESS;
	logic [31:0] WRITEDATA, READDATA, rd, wd, seed;
	logic [3:0]  BYTEENABLE, FAIL_THRESHOLD, LEGACY_RAM_SECTION_KEEP;
	logic [3:0]  be;
	logic [1:0]  RESPONSE, rsp;
	logic [7:0]  RAM_SECTION0_ON;
	logic [4:0]  ev;
	wire         CPU_STALL_EVENT, PIN_WAKE_EVENT, ANALOG_DETECT_SIGNAL;
	wire         DEBUG_ENTRY_EVENT, FIELD_DETECT_EVENT;
	int          err_total, tests_run, i;

	assign {FIELD_DETECT_EVENT, DEBUG_ENTRY_EVENT, ANALOG_DETECT_SIGNAL,
		PIN_WAKE_EVENT, CPU_STALL_EVENT} = ev;

	power_reset_status_regs power_reset_status_regs_inst (.CLOCK, .RST, .POR,
		.ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
		.WAITREQUEST, .RESPONSE, .CPU_STALL_EVENT, .PIN_WAKE_EVENT,
		.ANALOG_DETECT_SIGNAL, .DEBUG_ENTRY_EVENT, .FIELD_DETECT_EVENT,
		.RAM_SECTION0_ON, .DEEP_SLEEP_REQUEST, .FAIL_COMPARATOR_ENABLE,
		.FAIL_THRESHOLD, .LEGACY_RAM_SECTION_KEEP, .IRQ);

	function automatic logic [31:0] stat(input logic [7:0] s);
		return {28'h0, |s[7:6], |s[5:4], |s[3:2], |s[1:0]};
	endfunction
	function automatic logic [31:0] cause(input logic [4:0] c);
		return {12'h0, c[4:1], 12'h0, c[0], 3'h0};
	endfunction

	task automatic conclude;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge CLOCK);
		ADDRESS <= a;
		WRITEDATA <= d;
		BYTEENABLE <= be;
		READ <= !w;
		WRITE <= w;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (WAITREQUEST !== 1'h0 && n < 50);
		rd = READDATA;
		rsp = RESPONSE;
		READ <= 1'h0;
		WRITE <= 1'h0;
		if (WAITREQUEST !== 1'h0) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic rchk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge CLOCK);
		ev <= v;
		@(posedge CLOCK);
		ev <= 5'h0;
		@(negedge CLOCK);
	endtask

	initial begin
		CLOCK = 1'h0;
		forever #25 CLOCK = ~CLOCK;
	end

	initial begin
		seed = 32'h255A9A40;
		{err_total, tests_run} = 0;
		{RST, POR, READ, WRITE} = 4'hC;
		ADDRESS = 12'h000;
		WRITEDATA = 32'h0000_0000;
		BYTEENABLE = 4'h0;
		be = 4'hF;
		ev = 5'h0;
		RAM_SECTION0_ON = 8'h00;
		repeat (12) @(posedge CLOCK);
		RST <= 1'h0;
		POR <= 1'h0;
		rchk("cfg", OFS_FAIL_CONFIG, RST_FAIL_CONFIG);
		rchk("scr_a", OFS_SCRATCH_A, 32'h0);
		rchk("scr_b", OFS_SCRATCH_B, 32'h0);
		rchk("legacy", OFS_LEGACY_RAM, 32'h3);
		rchk("cause", OFS_RESET_CAUSE, 32'h0);
		rchk("unmapped", 12'h7FC, UNMAPPED_READ);
		chk("resp", 32'h0, {30'h0, rsp});
		chk("keep", 32'hF, {28'h0, LEGACY_RAM_SECTION_KEEP});
		for (i = 0; i < 9; i++) begin
			wd = i == 0 ? 32'h0 : i == 1 ? 32'h80 : $random(seed);
			RAM_SECTION0_ON <= wd[7:0];
			rchk("ram_stat", OFS_RAM_STATUS, stat(wd[7:0]));
		end
		// Threshold codes 4 to 15, with the enable bit at random
		for (i = 4; i < 16; i++) begin
			wd = $random(seed);
			wd[4:1] = 4'(i);
			bus(1'h1, OFS_FAIL_CONFIG, wd);
			@(negedge CLOCK);
			chk("thr", {27'h0, wd[4:0]},
				{27'h0, FAIL_THRESHOLD, FAIL_COMPARATOR_ENABLE});
			rchk("cfg", OFS_FAIL_CONFIG, {27'h0, wd[4:0]});
		end
		wd = $random(seed);
		bus(1'h1, OFS_SCRATCH_A, wd);
		bus(1'h1, OFS_SCRATCH_B, ~wd);
		// Legacy power register is written here to prove its map and, after RST, its retention
		bus(1'h1, OFS_LEGACY_RAM, 32'h1);
		@(negedge CLOCK);
		chk("keep", 32'h3, {28'h0, LEGACY_RAM_SECTION_KEEP});
		for (i = 0; i < 5; i++)
			pulse(5'h1 << i);
		// Bus-side reset alone must leave the retained state alone
		@(posedge CLOCK);
		RST <= 1'h1;
		repeat (3) @(posedge CLOCK);
		RST <= 1'h0;
		rchk("scr_a", OFS_SCRATCH_A, {24'h0, wd[7:0]});
		rchk("scr_b", OFS_SCRATCH_B, {24'h0, ~wd[7:0]});
		rchk("legacy", OFS_LEGACY_RAM, 32'h1);
		rchk("cfg", OFS_FAIL_CONFIG, 32'h0);
		rchk("cause", OFS_RESET_CAUSE, cause(5'h1F));
		for (i = 0; i < 5; i++) begin
			bus(1'h1, OFS_RESET_CAUSE, cause(5'h1 << i));
			rchk("cause", OFS_RESET_CAUSE,
				cause(5'(5'h1F << (i + 1))));
		end
		bus(1'h1, OFS_IRQ_MASK, 32'h1);
		pulse(5'h2);
		chk("irq", 32'h0, {31'h0, IRQ});
		pulse(5'h1);
		chk("irq", 32'h1, {31'h0, IRQ});
		bus(1'h1, OFS_IRQ_STATUS, 32'h1);
		@(negedge CLOCK);
		chk("irq", 32'h0, {31'h0, IRQ});
		rchk("irq_st", OFS_IRQ_STATUS, 32'h2);
		// Wake lane alone: the lock-up flag in lane 0 must survive
		be = 4'h4;
		bus(1'h1, OFS_RESET_CAUSE, 32'hFFFF_FFFF);
		be = 4'hF;
		rchk("cause_lane", OFS_RESET_CAUSE, cause(5'h01));
		for (i = 1; i >= 0; i--) begin
			bus(1'h1, OFS_SLEEP_TRIGGER, 32'(i));
			@(negedge CLOCK);
			chk("sleep", 32'(i), {31'h0, DEEP_SLEEP_REQUEST});
			@(negedge CLOCK);
			chk("sleep", 32'h0, {31'h0, DEEP_SLEEP_REQUEST});
		end
		conclude();
	end
endmodule
